/* bench/gspwm_host.sv */
// Purpose: host model driving shift, data, latch, blank and pwm count pins
// Assumes: device samples every pin through a synchroniser on i_sys_clk
// Notes: each shift, data, latch and blank phase lasts 8 system cycles and each pwm count phase 62 or 63 ns, so the agreement filter sees it
`timescale 1ns/1ns
`default_nettype none
module gspwm_host
  import gspwm_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_serial_out_line,
  output gspwm_pins_t o_pins
);
  initial o_pins = '{sck: 1'b0, sdi: 1'b0, latch: 1'b0, blank: 1'b1, pclk: 1'b0};
  task automatic hold();
    repeat (8) @(posedge i_sys_clk);
  endtask
  task automatic shift(input logic [191:0] p, output logic [191:0] q);
    for (int i = 191; i >= 0; i--) begin
      q[i] = i_serial_out_line;
      o_pins.sdi <= p[i];
      hold();
      o_pins.sck <= 1'b1;
      hold();
      o_pins.sck <= 1'b0;
    end
    hold();
    // Stale bit inverted so a missed sample never reads as data
    o_pins.sdi <= ~p[0];
  endtask
  // Shift lines stay still while the strobe is high; called with blank high only
  task automatic latch();
    o_pins.latch <= 1'b1;
    hold();
    o_pins.latch <= 1'b0;
    hold();
  endtask
  task automatic set_blank(input logic v);
    o_pins.blank <= v;
    hold();
  endtask
  // Free-running phase, unrelated to i_sys_clk; still between bursts
  task automatic pwm(input int n);
    repeat (n) begin
      #62 o_pins.pclk = 1'b1;
      #63 o_pins.pclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// Purpose: self-checking bench for the grayscale pwm core
// Assumes: host model drives all serial and pwm pins
// Notes: register reads go over classic Wishbone
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import gspwm_pkg::*;
;
  logic clk, rst_n, cyc, stb, we, ack, serial_out_line, err_n, ot;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, o_dat, q;
  logic [15:0] sense, chan;
  logic [191:0] p, r, e;
  gspwm_pins_t pins;
  int bad_count, total_checks, cnt;
  int lvl [16];
  gspwm_host host (.i_sys_clk(clk), .i_serial_out_line(serial_out_line), .o_pins(pins));
  gspwm_core DUT (.i_sys_clk(clk), .i_reset_n(rst_n), .i_shift_clock(pins.sck),
    .i_serial_in_line(pins.sdi), .i_latch_strobe(pins.latch), .i_blank(pins.blank),
    .i_pwm_count_clock(pins.pclk), .i_output_low_sense(sense), .i_overtemp_sense(ot),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(o_dat), .o_wb_ack(ack), .o_serial_out_line(serial_out_line),
    .o_channel_output(chan), .o_error_output_n(err_n));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [191:0] got, input logic [191:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, ack, 1'b1);
    end
    q = o_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic pulse_check(input int n);
    logic [15:0] x;
    host.pwm(n);
    cnt += n;
    repeat (3) @(posedge clk);
    for (int c = 0; c < 16; c++) x[c] = (lvl[c] > cnt) && (cnt < 4095);
    chk(192'(chan), 192'(x));
  endtask
  task automatic test_regs();
    wb(1'b0, GSPWM_ADDR_CTRL, 32'h0);
    chk(192'(q), 192'(GSPWM_CTRL_RESET));
    wb(1'b0, GSPWM_ADDR_CORR_BASE + 8'h04, 32'h0);
    chk(192'(q), 192'(GSPWM_CORR_RESET));
    wb(1'b1, 8'h30, 32'hffff_ffff);
    wb(1'b0, 8'h30, 32'h0);
    chk(192'(q), 192'(GSPWM_UNMAPPED));
    sel <= 4'he;
    wb(1'b1, GSPWM_ADDR_CTRL, 32'h2);
    sel <= 4'hf;
    wb(1'b0, GSPWM_ADDR_CTRL, 32'h0);
    chk(192'(q), 192'(GSPWM_CTRL_RESET));
    wb(1'b1, GSPWM_ADDR_CORR_BASE, 32'h15);
    wb(1'b1, GSPWM_ADDR_CTRL, 32'h1);
    wb(1'b0, GSPWM_ADDR_CORR_BASE, 32'h0);
    chk(192'(q), 192'h15);
    $display("test_regs done");
  endtask
  task automatic test_pwm();
    for (int c = 0; c < 16; c++) lvl[c] = (c == 15) ? 4095 : c;
    for (int c = 0; c < 16; c++) p[12*c +: 12] = 12'(lvl[c]);
    host.shift(p, r);
    host.latch();
    sense <= 16'h0004;
    ot <= 1'b1;
    host.set_blank(1'b0);
    cnt = 0;
    for (int k = 1; k <= 8; k++) pulse_check(1);
    chk(192'(err_n), 192'h0);
    pulse_check(4094 - 8);
    pulse_check(1);
    host.pwm(2);
    wb(1'b0, GSPWM_ADDR_COUNT, 32'h0);
    chk(192'(q[11:0]), 192'(GSPWM_COUNT_MAX));
    host.set_blank(1'b1);
    chk(192'(chan), 192'h0);
    wb(1'b0, GSPWM_ADDR_COUNT, 32'h0);
    chk(192'(q[11:0]), 192'(GSPWM_COUNT_ZERO));
    $display("test_pwm done");
  endtask
  task automatic test_status();
    e = '0;
    e[15:0] = 16'h0004;
    e[16] = 1'b1;
    for (int c = 0; c < 16; c++) e[24 + 6*c +: 6] = (c == 0) ? 6'h15 : 6'h3f;
    host.latch();
    host.shift(192'h0, r);
    chk(r, e);
    $display("test_status done");
  endtask
  task automatic test_early();
    host.set_blank(1'b0);
    host.pwm(3);
    wb(1'b0, GSPWM_ADDR_COUNT, 32'h0);
    chk(192'(q[11:0]), 192'h3);
    host.set_blank(1'b1);
    chk(192'(chan), 192'h0);
    wb(1'b0, GSPWM_ADDR_COUNT, 32'h0);
    chk(192'(q[11:0]), 192'h0);
    $display("test_early done");
  endtask
  initial begin
    {cyc, stb, we, ot} = 4'h0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
    sense = 16'h0000;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    test_regs();
    test_pwm();
    test_status();
    test_early();
    wrap_up();
  end
  initial begin
    // Roughly 70k cycles expected, mostly the full pwm cycle
    #700000;
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire

/* logic/gspwm_core.sv */
// Purpose: sixteen-channel grayscale PWM engine with serial load and status readout
// Assumes: pins are sampled by i_sys_clk; pwm count clock and shift clock are slow
// Notes: correction values and mode come from Wishbone registers
// How it works
// - Twelve-bit level per channel, duty level/4095
// - Packet 192 bits, sent MSB first
// - Program select low: grayscale mode, 192-bit shifter
// - Latch rise copies shifter into gray levels
// - After latch, shifter refilled with status packet
// - Bits 0-15 open flags, bit 16 overtemp
// - Bits 24-119 correction from storage or register
// - Status packet 192 bits, rest reserved zero
// - Serial out shows status MSB, then lower
// - Open flag set on low voltage at turn-on
// - Any valid open flag drives error low
// - PWM cycle starts at blank falling edge
// - First count pulse increments, turns channels on
// - Each later count edge increments counter
// - Channel turns off when level equals count
// - At FFFh counter stops, all outputs off
// - Blank high resets counter, ends cycle
// - Blank high disables outputs, holds counter reset
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module gspwm_core
  import gspwm_pkg::*;
#(
  parameter int unsigned CHANNELS = GSPWM_CHANNELS,
  parameter int unsigned LEVEL_W = GSPWM_LEVEL_W,
  parameter int unsigned PACKET_W = GSPWM_PACKET_W
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_shift_clock,
  input wire logic i_serial_in_line,
  input wire logic i_latch_strobe,
  input wire logic i_blank,
  input wire logic i_pwm_count_clock,
  input wire logic [CHANNELS-1:0] i_output_low_sense,
  input wire logic i_overtemp_sense,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_serial_out_line,
  output logic [CHANNELS-1:0] o_channel_output,
  output logic o_error_output_n
);
  localparam int unsigned CW = GSPWM_CORR_W;

  gspwm_pins_t pins_raw, pins;

  always_comb begin
    pins_raw.sck = i_shift_clock;
    pins_raw.sdi = i_serial_in_line;
    pins_raw.latch = i_latch_strobe;
    pins_raw.blank = i_blank;
    pins_raw.pclk = i_pwm_count_clock;
  end

  gspwm_sync #(
    .WIDTH($bits(gspwm_pins_t))
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_async(pins_raw),
    .o_sync(pins)
  );

  typedef enum logic [2:0] {
    PWM_IDLE = 3'b001,
    PWM_RUN = 3'b010,
    PWM_DONE = 3'b100
  } gspwm_pwm_t;

  typedef struct packed {
    gspwm_pins_t prev;
    logic [PACKET_W-1:0] shreg;
    logic [CHANNELS*LEVEL_W-1:0] levels;
    logic [CHANNELS*CW-1:0] corr_reg;
    logic [CHANNELS*CW-1:0] corr_store;
    logic src_sel;
    logic prog_sel;
    gspwm_pwm_t pwm;
    logic [LEVEL_W-1:0] count;
    logic [CHANNELS-1:0] chan;
    logic [CHANNELS-1:0] open_flags;
    logic overtemp;
    logic [CHANNELS-1:0] sense_r;
    logic err_n;
    logic serial_out_line;
    logic ack;
    logic [31:0] rdat;
  } gspwm_st_t;

  gspwm_st_t st_r, st_nxt;
  logic sck_rise, latch_rise, blank_fall, pclk_rise;
  logic [PACKET_W-1:0] status_pkt;
  logic [CHANNELS-1:0] hit;
  logic [CHANNELS-1:0] nonzero;
  logic wb_req;
  logic [3:0] corr_idx;
  logic corr_hit;

  assign sck_rise = pins.sck && !st_r.prev.sck;
  assign latch_rise = pins.latch && !st_r.prev.latch;
  assign blank_fall = !pins.blank && st_r.prev.blank;
  assign pclk_rise = pins.pclk && !st_r.prev.pclk;
  assign wb_req = i_wb_cyc && i_wb_stb && !st_r.ack;
  assign corr_hit = (i_wb_adr >= GSPWM_ADDR_CORR_BASE) && (i_wb_adr <= GSPWM_ADDR_CORR_END);
  assign corr_idx = 4'((i_wb_adr - GSPWM_ADDR_CORR_BASE) >> 2);

  // Per-channel compare and status packet layout
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      assign hit[g] = (st_r.levels[g*LEVEL_W +: LEVEL_W] == st_r.count);
      assign nonzero[g] = (st_r.levels[g*LEVEL_W +: LEVEL_W] != GSPWM_LEVEL_OFF);
    end
  endgenerate

  always_comb begin
    status_pkt = '0;
    status_pkt[CHANNELS-1:0] = st_r.open_flags;
    status_pkt[GSPWM_FLAG_OT_POS] = st_r.overtemp;
    status_pkt[GSPWM_CORR_HI:GSPWM_CORR_LO] = st_r.src_sel ? st_r.corr_reg : st_r.corr_store;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = pins;
    st_nxt.sense_r = i_output_low_sense;
    st_nxt.overtemp = i_overtemp_sense;

    // Serial path; only live in grayscale mode
    if (!st_r.prog_sel) begin
      if (latch_rise) begin
        st_nxt.levels = st_r.shreg[CHANNELS*LEVEL_W-1:0];
        st_nxt.shreg = status_pkt;
        st_nxt.serial_out_line = status_pkt[PACKET_W-1];
      end else if (sck_rise && !pins.latch) begin
        st_nxt.shreg = {st_r.shreg[PACKET_W-2:0], pins.sdi};
        st_nxt.serial_out_line = st_r.shreg[PACKET_W-2];
      end
    end

    // Counter and outputs
    if (pins.blank) begin
      st_nxt.pwm = PWM_IDLE;
      st_nxt.count = GSPWM_COUNT_ZERO;
      st_nxt.chan = '0;
    end else begin
      unique case (st_r.pwm)
        PWM_IDLE: begin
          if (pclk_rise) begin
            st_nxt.count = st_r.count + LEVEL_W'(1);
            st_nxt.chan = nonzero;
            st_nxt.pwm = PWM_RUN;
          end
        end
        PWM_RUN: begin
          st_nxt.chan = st_r.chan & ~hit;
          if (st_r.count == GSPWM_COUNT_MAX) begin
            st_nxt.chan = '0;
            st_nxt.pwm = PWM_DONE;
          end else if (pclk_rise) begin
            st_nxt.count = st_r.count + LEVEL_W'(1);
          end
        end
        PWM_DONE: begin
          st_nxt.chan = '0;
        end
      endcase
    end

    // Open detection is taken every cycle a channel is on, from one cycle after it turns on
    for (int i = 0; i < int'(CHANNELS); i++) begin
      if (st_r.chan[i] && !st_r.prev.blank && st_r.sense_r[i]) begin
        st_nxt.open_flags[i] = 1'b1;
      end
    end
    if (blank_fall) begin
      st_nxt.open_flags = '0;
    end
    st_nxt.err_n = ~|st_nxt.open_flags;

    // Wishbone slave, one wait state
    st_nxt.ack = wb_req;
    st_nxt.rdat = GSPWM_UNMAPPED;
    if (wb_req) begin
      if (i_wb_we && i_wb_sel[0]) begin
        if (i_wb_adr == GSPWM_ADDR_CTRL) begin
          st_nxt.src_sel = i_wb_dat[GSPWM_CTRL_SRC_POS];
          st_nxt.prog_sel = i_wb_dat[GSPWM_CTRL_PROG_POS];
        end else if (corr_hit) begin
          st_nxt.corr_reg[corr_idx*CW +: CW] = i_wb_dat[CW-1:0];
        end
      end
      if (!i_wb_we) begin
        if (i_wb_adr == GSPWM_ADDR_CTRL) begin
          st_nxt.rdat[GSPWM_CTRL_SRC_POS] = st_r.src_sel;
          st_nxt.rdat[GSPWM_CTRL_PROG_POS] = st_r.prog_sel;
        end else if (i_wb_adr == GSPWM_ADDR_STATUS) begin
          st_nxt.rdat[GSPWM_FLAG_OT_POS] = st_r.overtemp;
          st_nxt.rdat[2:0] = st_r.pwm;
        end else if (i_wb_adr == GSPWM_ADDR_OPEN) begin
          st_nxt.rdat[CHANNELS-1:0] = st_r.open_flags;
        end else if (i_wb_adr == GSPWM_ADDR_COUNT) begin
          st_nxt.rdat[LEVEL_W-1:0] = st_r.count;
        end else if (corr_hit) begin
          st_nxt.rdat[CW-1:0] = st_r.corr_reg[corr_idx*CW +: CW];
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '0;
      st_r.pwm <= PWM_IDLE;
      // Matches the synchroniser's reset output so no false blank edge follows reset
      st_r.prev.blank <= 1'b0;
      st_r.corr_reg <= {CHANNELS{GSPWM_CORR_RESET}};
      st_r.corr_store <= {CHANNELS{GSPWM_CORR_RESET}};
      st_r.err_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_serial_out_line = st_r.serial_out_line;
  assign o_channel_output = st_r.chan;
  assign o_error_output_n = st_r.err_n;
  assign o_wb_ack = st_r.ack;
  assign o_wb_dat = st_r.rdat;

  // Assertions
  sequence latch_seen_s;
    !st_r.prog_sel && latch_rise;
  endsequence

  latch_loads_levels_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    latch_seen_s |=> (st_r.levels == $past(st_r.shreg[CHANNELS*LEVEL_W-1:0])))
    else $error("latch did not load levels");
  status_reload_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    latch_seen_s |=> (st_r.shreg == $past(status_pkt)))
    else $error("status packet not loaded");
  status_msb_out_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    latch_seen_s |=> (o_serial_out_line == $past(status_pkt[PACKET_W-1])))
    else $error("serial out not status msb");
  blank_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    pins.blank |=> (o_channel_output == '0) && (st_r.count == GSPWM_COUNT_ZERO))
    else $error("outputs live during blank");
  count_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_r.pwm == PWM_RUN && pclk_rise && !pins.blank && st_r.count != GSPWM_COUNT_MAX)
      |=> st_r.count == $past(st_r.count) + LEVEL_W'(1))
    else $error("counter did not step");
  count_stop_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_r.count == GSPWM_COUNT_MAX && !pins.blank) |=> ##1 (o_channel_output == '0))
    else $error("outputs on at full count");
  first_on_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_r.pwm == PWM_IDLE && pclk_rise && !pins.blank) |=> (o_channel_output == $past(nonzero)))
    else $error("first pulse did not turn channels on");
  error_pin_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (|st_r.open_flags) |-> !o_error_output_n)
    else $error("error pin not low with open flag");
  shift_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (!st_r.prog_sel && sck_rise && !pins.latch && !latch_rise)
      |=> st_r.shreg[0] == $past(pins.sdi))
    else $error("serial in not shifted");
endmodule
`default_nettype wire

/* logic/gspwm_sync.sv */
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs are asynchronous to i_sys_clk
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module gspwm_sync #(
  parameter int unsigned WIDTH = 5
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } gspwm_sync_st_t;

  gspwm_sync_st_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < int'(WIDTH); i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.q;
endmodule
`default_nettype wire

/* shared/gspwm_pkg.sv */
// Purpose: shared constants and carrier types for the grayscale PWM block
// Assumes: 16 channels, 12-bit gray levels, 192-bit packets
// Notes: register map constants are word byte addresses
package gspwm_pkg;
  localparam int unsigned GSPWM_CHANNELS = 16;
  localparam int unsigned GSPWM_LEVEL_W = 12;
  localparam int unsigned GSPWM_PACKET_W = 192;
  localparam int unsigned GSPWM_CORR_W = 6;
  localparam int unsigned GSPWM_FLAG_OT_POS = 16;
  localparam int unsigned GSPWM_CORR_LO = 24;
  localparam int unsigned GSPWM_CORR_HI = 119;
  localparam logic [11:0] GSPWM_COUNT_MAX = 12'hfff;
  localparam logic [11:0] GSPWM_COUNT_ZERO = 12'h000;
  localparam logic [11:0] GSPWM_LEVEL_OFF = 12'h000;
  localparam int unsigned GSPWM_TPD_OPEN_NS = 1510;
  localparam int unsigned GSPWM_CLK_NS = 8;
  // Open-flag settle window, least time rounded up
  localparam int unsigned GSPWM_OPEN_SETTLE_CYC = (GSPWM_TPD_OPEN_NS + GSPWM_CLK_NS - 1) / GSPWM_CLK_NS;

  // Wishbone register map
  localparam logic [7:0] GSPWM_ADDR_CTRL = 8'h00;
  localparam logic [7:0] GSPWM_ADDR_STATUS = 8'h04;
  localparam logic [7:0] GSPWM_ADDR_OPEN = 8'h08;
  localparam logic [7:0] GSPWM_ADDR_COUNT = 8'h0c;
  localparam logic [7:0] GSPWM_ADDR_CORR_BASE = 8'h40;
  localparam logic [7:0] GSPWM_ADDR_CORR_END = 8'h7c;
  localparam int unsigned GSPWM_CTRL_SRC_POS = 0;
  localparam int unsigned GSPWM_CTRL_PROG_POS = 1;
  localparam logic [31:0] GSPWM_CTRL_RESET = 32'h0000_0000;
  localparam logic [5:0] GSPWM_CORR_RESET = 6'h3f;
  localparam logic [31:0] GSPWM_UNMAPPED = 32'h0000_0000;

  typedef struct packed {
    logic sck;
    logic sdi;
    logic latch;
    logic blank;
    logic pclk;
  } gspwm_pins_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } gspwm_wb_req_t;
endpackage
